//--- verification/hscr_regs_monitor.sv
// checker: port assertions for the hyp control register
`timescale 1ns/1ns
`default_nettype none
module hscr_regs_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire hscr_pkg::hscr_req_s req,
  input wire logic [4:0] cpu_mode,
  input wire logic nonsecure_state_flag,
  input wire logic hyp_exception_entry,
  input wire logic tt_walk_hyp,
  input wire logic tt_desc_writable,
  input wire hscr_pkg::hscr_rsp_s rsp,
  input wire hscr_pkg::hscr_ctrl_s ctrl,
  input wire logic status_endian_flag,
  input wire logic status_endian_load,
  input wire logic tt_big_endian,
  input wire logic no_exec_attr
);
  import hscr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire ok = cpu_mode == HSCR_MODE_HYP || (cpu_mode == HSCR_MODE_MON && nonsecure_state_flag);
  wire [6:0] ws = {req.wdata[30], req.wdata[25], req.wdata[19], req.wdata[12], req.wdata[2:0]};
  wire calm = !req.valid;
  sequence ctrl_wr_s;
    req.valid && req.write && ok && req.opc2 == HSCR_OPC2_CTRL ##1 !rsp.undef;
  endsequence
  answer_next_a: assert property (req.valid |=> rsp.valid) else $error("late");
  refuse_mode_a: assert property (req.valid && !ok |=> rsp.undef && rsp.rdata == 32'h0) else $error("mode");
  refuse_code_a: assert property (req.valid && req.opc2 > HSCR_OPC2_AUX |=> rsp.undef) else $error("code");
  fixed_bits_a: assert property (rsp.valid && !rsp.undef && !$past(req.write) && $past(req.opc2) == 3'h0
    |-> (rsp.rdata & ~HSCR_WRITE_MASK) == HSCR_RAO_MASK) else $error("fixed");
  ctrl_follow_a: assert property (ctrl_wr_s |=> ctrl == $past(ws, 2)) else $error("ctrl");
  status_copy_a: assert property (hyp_exception_entry && calm && !$past(req.valid)
    |=> status_endian_load && status_endian_flag == $past(ctrl.exc_big_endian)) else $error("entry");
  walk_endian_a: assert property (tt_walk_hyp && calm && !$past(req.valid)
    |=> tt_big_endian == $past(ctrl.exc_big_endian)) else $error("order");
  no_exec_a: assert property (tt_walk_hyp && calm && !$past(req.valid)
    |=> no_exec_attr == ($past(tt_desc_writable) && $past(ctrl.write_forces_no_exec))) else $error("xn");
endmodule
bind hscr_regs hscr_regs_monitor hscr_regs_monitor_inst (.*);
`default_nettype wire

//--- verification/testbench.sv
// testbench: register access, side outputs, privilege
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import hscr_pkg::*;
  logic clock = 0, rst = 1, entry = 0, walk = 0, wr_ok = 0, ns = 0;
  logic [4:0] mode = HSCR_MODE_HYP;
  hscr_req_s req = '0;
  hscr_rsp_s rsp;
  hscr_ctrl_s ctrl;
  logic sef, sel, tbe, nxa;
  int n_mismatch = 0, checked = 0;
  always #5 clock = ~clock;
  hscr_regs hscr_regs_inst (.clock(clock), .rst(rst), .req(req), .cpu_mode(mode), .nonsecure_state_flag(ns),
    .hyp_exception_entry(entry), .tt_walk_hyp(walk), .tt_desc_writable(wr_ok), .rsp(rsp), .ctrl(ctrl),
    .status_endian_flag(sef), .status_endian_load(sel), .tt_big_endian(tbe), .no_exec_attr(nxa));
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] o2, input logic [31:0] d, input logic u, input logic [31:0] e);
    req = '{1'b1, w, HSCR_OPC1, HSCR_CRN, HSCR_CRM_CTRL, o2, d};
    @(negedge clock);
    cmp({rsp.valid, rsp.undef, rsp.rdata}, {1'b1, u, e});
    req.valid = 1'b0;
    // idle cycle so the next call never re-raises valid in this time step
    @(negedge clock);
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    rst = 0;
    acc(0, 0, 0, 0, 32'h30C5_0878);
    acc(1, 0, 32'hFFFF_FFFF, 0, 0);
    acc(0, 0, 0, 0, 32'h72CD_187F);
    cmp({27'h0, ctrl}, 34'h7F);
    $display("test write done");
    @(negedge clock);
    entry = 1;
    walk = 1;
    wr_ok = 1;
    @(negedge clock);
    entry = 0;
    wr_ok = 0;
    cmp({30'h0, sel, sef, tbe, nxa}, 34'hF);
    @(negedge clock);
    cmp({31'h0, sel, tbe, nxa}, 34'h2);
    $display("test side done");
    mode = 5'h10;
    acc(1, 0, 0, 1, 0);
    mode = HSCR_MODE_MON;
    acc(1, 0, 0, 1, 0);
    ns = 1;
    acc(1, 0, 32'h4000_0000, 0, 0);
    acc(0, 3'h5, 0, 1, 0);
    acc(1, 1, 32'hFFFF_FFFF, 0, 0);
    acc(0, 1, 0, 0, 0);
    acc(0, 0, 0, 0, 32'h70C5_0878);
    wr_ok = 1;
    @(negedge clock);
    cmp({25'h0, tbe, nxa, ctrl}, 34'h40);
    $display("test privilege done");
    results();
  end
endmodule
`default_nettype wire

//--- verilog/hscr_access_check.sv
// module: privilege check for hyp register accesses
`timescale 1ns/1ns
`default_nettype none

module hscr_access_check (
  input wire logic [4:0] cpu_mode,
  input wire logic nonsecure_state_flag,
  output logic allowed
);
  import hscr_pkg::*;

  always_comb begin
    allowed = (cpu_mode == HSCR_MODE_HYP) ||
              ((cpu_mode == HSCR_MODE_MON) && nonsecure_state_flag);
  end

endmodule

`default_nettype wire

//--- verilog/hscr_pkg.sv
// package: constants and carrier types of the hyp system control register block
package hscr_pkg;

  // coprocessor access encoding
  localparam logic [3:0] HSCR_CP_NUM = 4'hF;
  localparam logic [2:0] HSCR_OPC1 = 3'h4;
  localparam logic [3:0] HSCR_CRN = 4'h1;
  localparam logic [3:0] HSCR_CRM_CTRL = 4'h0;
  localparam logic [2:0] HSCR_OPC2_CTRL = 3'h0;
  localparam logic [3:0] HSCR_CRM_AUX = 4'h0;
  localparam logic [2:0] HSCR_OPC2_AUX = 3'h1;

  // field positions
  localparam int HSCR_BIT_STATE_SEL = 30;
  localparam int HSCR_BIT_BYTE_ORDER = 25;
  localparam int HSCR_BIT_FAST_IRQ = 21;
  localparam int HSCR_BIT_WXN = 19;
  localparam int HSCR_BIT_ICACHE = 12;
  localparam int HSCR_BIT_DCACHE = 2;
  localparam int HSCR_BIT_ALIGN = 1;
  localparam int HSCR_BIT_MMU = 0;

  // writable bits, reserved read-as-one bits, value after reset
  localparam logic [31:0] HSCR_WRITE_MASK = 32'h4208_1007;
  localparam logic [31:0] HSCR_RAO_MASK = 32'h30C5_0878;
  localparam logic [31:0] HSCR_RESET_VAL = 32'h0000_0000;
  // value returned for the unimplemented auxiliary register
  localparam logic [31:0] HSCR_AUX_READ_VAL = 32'h0000_0000;

  // processor mode encodings
  localparam logic [4:0] HSCR_MODE_HYP = 5'h1A;
  localparam logic [4:0] HSCR_MODE_MON = 5'h16;

  typedef enum logic [0:0] {
    HSCR_ST_IDLE,
    HSCR_ST_ANSWER
  } hscr_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } hscr_req_s;

  typedef struct packed {
    logic valid;
    logic undef;
    logic [31:0] rdata;
  } hscr_rsp_s;

  typedef struct packed {
    logic exc_compact_state;
    logic exc_big_endian;
    logic write_forces_no_exec;
    logic icache_en;
    logic dcache_en;
    logic align_check_en;
    logic mmu_en;
  } hscr_ctrl_s;

endpackage

//--- verilog/hscr_regs.sv
// module: hyp system control register with its control outputs
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - access only hyp, or monitor when nonsecure
// - bit 30 selects exception instruction state
// - exception entry copies bit 25 to endianness
// - bit 25 sets translation table byte order
// - bit 21 reads zero, writes ignored
// - bit 19 forces writable hyp pages no-exec
// - bit 12 enables instruction caches
// - bit 2 enables data and unified caches
// - bit 1 enables alignment fault checking
// - bit 0 enables stage 1 translation
// - auxiliary register unimplemented, reads zero
module hscr_regs (
  input wire logic clock,
  input wire logic rst,
  input wire hscr_pkg::hscr_req_s req,
  input wire logic [4:0] cpu_mode,
  input wire logic nonsecure_state_flag,
  input wire logic hyp_exception_entry,
  input wire logic tt_walk_hyp,
  input wire logic tt_desc_writable,
  output hscr_pkg::hscr_rsp_s rsp,
  output hscr_pkg::hscr_ctrl_s ctrl,
  output logic status_endian_flag,
  output logic status_endian_load,
  output logic tt_big_endian,
  output logic no_exec_attr
);
  import hscr_pkg::*;

  logic [31:0] hyp_system_control;
  logic allowed;
  logic hit_ctrl;
  logic hit_aux;
  logic [31:0] read_view;
  hscr_state_e state;

  hscr_access_check u_check (
    .cpu_mode(cpu_mode),
    .nonsecure_state_flag(nonsecure_state_flag),
    .allowed(allowed)
  );

  always_comb begin
    hit_ctrl = (req.opc1 == HSCR_OPC1) && (req.crn == HSCR_CRN) &&
               (req.crm == HSCR_CRM_CTRL) && (req.opc2 == HSCR_OPC2_CTRL);
    hit_aux = (req.opc1 == HSCR_OPC1) && (req.crn == HSCR_CRN) &&
              (req.crm == HSCR_CRM_AUX) && (req.opc2 == HSCR_OPC2_AUX);
    // fast irq bit is outside the write mask, so it stays zero
    read_view = (hyp_system_control & HSCR_WRITE_MASK) | HSCR_RAO_MASK;
  end

  // register update: only writable bits, only from permitted modes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hyp_system_control <= HSCR_RESET_VAL;
    end else if (req.valid && req.write && hit_ctrl && allowed) begin
      hyp_system_control <= req.wdata & HSCR_WRITE_MASK;
    end
  end

  // one-cycle answer to each request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= HSCR_ST_IDLE;
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.undef <= 1'b0;
      rsp.rdata <= 32'h0000_0000;
      case (state)
        HSCR_ST_IDLE,
        HSCR_ST_ANSWER: begin
          state <= req.valid ? HSCR_ST_ANSWER : HSCR_ST_IDLE;
          if (req.valid) begin
            if (!allowed || !(hit_ctrl || hit_aux)) begin
              rsp.undef <= 1'b1;
            end else if (hit_aux) begin
              // aux writes are dropped; reads give a fixed value
              rsp.rdata <= HSCR_AUX_READ_VAL;
            end else if (!req.write) begin
              rsp.rdata <= read_view;
            end
          end
        end
        default: begin
          state <= HSCR_ST_IDLE;
        end
      endcase
    end
  end

  // control fields driven to the core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      ctrl.exc_compact_state <= hyp_system_control[HSCR_BIT_STATE_SEL];
      ctrl.exc_big_endian <= hyp_system_control[HSCR_BIT_BYTE_ORDER];
      ctrl.write_forces_no_exec <= hyp_system_control[HSCR_BIT_WXN];
      ctrl.icache_en <= hyp_system_control[HSCR_BIT_ICACHE];
      ctrl.dcache_en <= hyp_system_control[HSCR_BIT_DCACHE];
      ctrl.align_check_en <= hyp_system_control[HSCR_BIT_ALIGN];
      ctrl.mmu_en <= hyp_system_control[HSCR_BIT_MMU];
    end
  end

  // endianness loaded into the status register on hyp exception entry
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_endian_flag <= 1'b0;
      status_endian_load <= 1'b0;
    end else begin
      status_endian_load <= hyp_exception_entry;
      if (hyp_exception_entry) begin
        status_endian_flag <= hyp_system_control[HSCR_BIT_BYTE_ORDER];
      end
    end
  end

  // table walk byte order and execute-never forcing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tt_big_endian <= 1'b0;
      no_exec_attr <= 1'b0;
    end else begin
      tt_big_endian <= tt_walk_hyp & hyp_system_control[HSCR_BIT_BYTE_ORDER];
      no_exec_attr <= tt_walk_hyp & tt_desc_writable & hyp_system_control[HSCR_BIT_WXN];
    end
  end

endmodule

`default_nettype wire
